// ---- core/wtmr_pkg.sv ----
// Purpose: constants and types shared by the watch interval timer
// Assumes: 8-bit control register, word-aligned register port
// Notes: offsets are byte addresses on the plain register port
package wtmr_pkg;
  localparam logic [31:0] WTMR_CTRL_OFS = 32'hfffff360;
  localparam logic [31:0] WTMR_STAT_OFS = 32'hfffff364;
  localparam logic [31:0] WTMR_MASK_OFS = 32'hfffff368;
  localparam logic [7:0] WTMR_CTRL_RST = 8'h00;
  localparam logic [1:0] WTMR_STAT_RST = 2'h0;
  localparam logic [1:0] WTMR_MASK_RST = 2'h0;
  localparam int WTMR_CLK_SRC_BIT = 7;
  localparam int WTMR_IVL_HI_BIT = 6;
  localparam int WTMR_IVL_LO_BIT = 4;
  localparam int WTMR_PER_BIT = 3;
  localparam int WTMR_RSVD_BIT = 2;
  localparam int WTMR_RUN_BIT = 1;
  localparam int WTMR_EN_BIT = 0;
  localparam int WTMR_EVT_WATCH = 0;
  localparam int WTMR_EVT_IVL = 1;
  localparam int WTMR_PRE_W = 9;
  localparam int WTMR_CNT_W = 5;
  localparam int WTMR_MAIN_DIV = 512;
  localparam logic [2:0] WTMR_IVL_MAX = 3'h5;
  localparam int WTMR_IVL_BASE_EXP = 4;
  typedef struct packed {
    logic clock_source_select;
    logic [2:0] interval_select;
    logic watch_period_select;
    logic rsvd;
    logic counter_run;
    logic watch_enable;
  } wtmr_ctrl_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
    logic wr;
    logic rd;
  } wtmr_bus_t;
endpackage

// ---- core/wtmr_top.sv ----
// Purpose: watch timer with interval tap, one 8-bit control register
// Assumes: subclock arrives asynchronously on a pin; main clock is clk
// Notes: bus byte mask lets software change single bits
// How it works
// - watch interrupt every 2^14 or 2^5 watch clocks
// - watch and interval events run together
// - counter counts only while run and enable set; prescaler needs enable only
// - both bits clear resets prescaler and counter
// - bit 7 picks main/512 or subclock
// - bits 6..4 choose interval tap 2^4..2^9
// - bit 3 picks 2^14 or 2^5 period
// - run bit 0 clears counter, 1 starts
// - enable 0 holds prescaler and counter cleared
// - reset forces control register to zero
// - run clear resets counter, prescaler continues
// - enable clear resets prescaler and counter
// - first watch event waits full count when run and enable are set in the same write
// - bit-masked writes change only addressed bits
// - both clock sources give same period in watch clocks
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module wtmr_top #(
  parameter int MAIN_DIV = 512
) (
  input wire logic clk,
  input wire logic nrst,
  input wire wtmr_pkg::wtmr_bus_t bus,
  input wire logic subclk,
  output logic [7:0] rdata,
  output logic watch_interrupt,
  output logic interval_interrupt,
  output logic irq
);
  import wtmr_pkg::*;

  wtmr_ctrl_t ctrl_ff;
  logic [1:0] stat_ff;
  logic [1:0] mask_ff;
  logic [7:0] rdata_ff;
  logic [WTMR_PRE_W-1:0] pre_ff;
  logic [WTMR_CNT_W-1:0] cnt_ff;
  logic [8:0] mdiv_ff;
  logic [2:0] sub_sync_ff;
  logic watch_ff;
  logic ivl_ff;
  logic irq_ff;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // bus decode
  wire wr_ctrl = bus.wr && bus.addr == WTMR_CTRL_OFS;
  wire wr_stat = bus.wr && bus.addr == WTMR_STAT_OFS;
  wire wr_mask = bus.wr && bus.addr == WTMR_MASK_OFS;
  wire [7:0] ctrl_merged = merge(ctrl_ff, bus.wdata, bus.wmask);
  wire [7:0] nxt_ctrl = {ctrl_merged[7:3], 1'b0, ctrl_merged[1:0]};
  wire [7:0] mask_merged = merge({6'h00, mask_ff}, bus.wdata, bus.wmask);
  wire [1:0] nxt_mask = wr_mask ? mask_merged[1:0] : mask_ff;
  wire [1:0] stat_clr = wr_stat ? (bus.wdata[1:0] & bus.wmask[1:0]) : 2'h0;
  wire [7:0] rd_mux = (bus.addr == WTMR_CTRL_OFS) ? ctrl_ff :
                      (bus.addr == WTMR_STAT_OFS) ? {6'h00, stat_ff} :
                      (bus.addr == WTMR_MASK_OFS) ? {6'h00, mask_ff} : 8'h00;

  // watch clock ticks: main divide or synchronised subclock rising edge
  wire mdiv_tick = mdiv_ff == 9'(MAIN_DIV - 1);
  wire sub_tick = sub_sync_ff[1] & ~sub_sync_ff[2];
  wire wclk_tick = ctrl_ff.clock_source_select ? sub_tick : mdiv_tick;
  wire en = ctrl_ff.watch_enable;
  wire run = ctrl_ff.counter_run & ctrl_ff.watch_enable;
  wire pre_step = en && wclk_tick;
  wire pre_wrap = pre_step && (&pre_ff);
  // tap mask: low (4+sel) bits all ones; prohibited codes treated as max tap
  wire [2:0] ivl_sel = (ctrl_ff.interval_select > WTMR_IVL_MAX) ? WTMR_IVL_MAX : ctrl_ff.interval_select;
  // four bits for the shift amount: 5 + 4 would wrap in three bits
  wire [3:0] tap_exp = {1'b0, ivl_sel} + 4'(WTMR_IVL_BASE_EXP);
  wire [9:0] tap_full = (10'h001 << tap_exp) - 10'h001;
  wire [8:0] tap_mask = tap_full[8:0];
  wire ivl_evt = pre_step && ((pre_ff & tap_mask) == tap_mask);
  // 2^14 = prescaler wrap and counter wrap; 2^5 = low five prescaler bits
  wire watch_evt = ctrl_ff.watch_period_select ?
                   (run && pre_step && (&pre_ff[4:0])) :
                   (run && pre_wrap && (&cnt_ff));
  wire [1:0] evt = {ivl_evt, watch_evt};
  wire [1:0] nxt_stat = (stat_ff & ~stat_clr) | evt;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_ff <= WTMR_CTRL_RST;
      mask_ff <= WTMR_MASK_RST;
    end else begin
      if (wr_ctrl) ctrl_ff <= nxt_ctrl;
      mask_ff <= nxt_mask;
    end
  end

  // set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (!nrst) stat_ff <= WTMR_STAT_RST;
    else stat_ff <= nxt_stat;
  end

  always_ff @(posedge clk) begin
    if (!nrst) mdiv_ff <= 9'h000;
    else mdiv_ff <= mdiv_tick ? 9'h000 : mdiv_ff + 9'h001;
  end

  always_ff @(posedge clk) begin
    if (!nrst) sub_sync_ff <= 3'h0;
    else sub_sync_ff <= {sub_sync_ff[1:0], subclk};
  end

  always_ff @(posedge clk) begin
    if (!nrst) pre_ff <= '0;
    else if (!en) pre_ff <= '0;
    else if (pre_step) pre_ff <= pre_ff + 9'h001;
  end

  always_ff @(posedge clk) begin
    if (!nrst) cnt_ff <= '0;
    else if (!run) cnt_ff <= '0;
    else if (pre_wrap) cnt_ff <= cnt_ff + 5'h01;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_ff <= 8'h00;
      watch_ff <= 1'b0;
      ivl_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      rdata_ff <= bus.rd ? rd_mux : 8'h00;
      watch_ff <= watch_evt;
      ivl_ff <= ivl_evt;
      // next status and next mask, so irq tracks the flops with no extra cycle
      irq_ff <= |(nxt_stat & nxt_mask);
    end
  end

  assign rdata = rdata_ff;
  assign watch_interrupt = watch_ff;
  assign interval_interrupt = ivl_ff;
  assign irq = irq_ff;

  AST_RST_CTRL: assert property (@(posedge clk) !nrst |=> ctrl_ff == 8'h00)
    else $error("control not cleared by reset");
  AST_STOP_CLR: assert property (@(posedge clk) disable iff (!nrst) !en |=> pre_ff == '0 && cnt_ff == '0)
    else $error("stopped block not cleared");
  AST_RUN_CLR: assert property (@(posedge clk) disable iff (!nrst) (en && !ctrl_ff.counter_run) |=> cnt_ff == '0)
    else $error("counter not cleared by run bit");
  AST_NO_WATCH_STOP: assert property (@(posedge clk) disable iff (!nrst) !run |=> !watch_interrupt)
    else $error("watch event while stopped");
  AST_RSVD: assert property (@(posedge clk) disable iff (!nrst) ctrl_ff[WTMR_RSVD_BIT] == 1'b0)
    else $error("reserved bit set");
  AST_MASKED_WR: assert property (@(posedge clk) disable iff (!nrst)
    (wr_ctrl && bus.wmask == 8'h01) |=> ctrl_ff[7:1] == $past(ctrl_ff[7:1]))
    else $error("bit write touched other bits");
  AST_STICKY: assert property (@(posedge clk) disable iff (!nrst) watch_evt |=> stat_ff[WTMR_EVT_WATCH])
    else $error("watch event not latched");
  AST_IVL_PRE: assert property (@(posedge clk) disable iff (!nrst) ivl_evt |=> pre_ff[3:0] == 4'h0)
    else $error("interval not on tap boundary");
  AST_IRQ: assert property (@(posedge clk) disable iff (!nrst) irq == (|(stat_ff & mask_ff)))
    else $error("irq missing");
  COV_WATCH: cover property (@(posedge clk) watch_interrupt);
  COV_IVL: cover property (@(posedge clk) interval_interrupt);
  COV_BOTH: cover property (@(posedge clk) watch_evt && ivl_evt);
  COV_SUB: cover property (@(posedge clk) ctrl_ff.clock_source_select && pre_wrap);
endmodule

// ---- tb/tb_wtmr_top.sv ----
// Purpose: self-checking bench for the watch interval timer
// Assumes: main divider shortened to 4 clocks; subclock from a slow counter
// Notes: periods measured pulse to pulse, so synchroniser lag cancels out
`timescale 1ns/1ps
module tb_wtmr_top;
  import wtmr_pkg::*;
  localparam int DIV = 4;
  localparam int SUBH = 5;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic subclk = 1'b0;
  logic [3:0] sc = 4'h0;
  wtmr_bus_t bus = '0;
  logic [7:0] rdata;
  logic watch_interrupt;
  logic interval_interrupt;
  logic irq;
  int failures = 0;
  int checks = 0;
  int f;
  int n;
  wtmr_top #(.MAIN_DIV(DIV)) uut (.clk(clk), .nrst(nrst), .bus(bus), .subclk(subclk), .rdata(rdata),
    .watch_interrupt(watch_interrupt), .interval_interrupt(interval_interrupt), .irq(irq));
  initial begin
    forever #5 clk = ~clk;
  end
  // free-running subclock, one rising edge every 2*SUBH clocks
  always @(posedge clk) begin
    sc <= (sc == SUBH - 1) ? 4'h0 : sc + 4'h1;
    if (sc == SUBH - 1) subclk <= ~subclk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [31:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk) bus <= '{a, d, m, 1'b1, 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask
  task rd(input logic [31:0] a, input logic [7:0] e);
    @(posedge clk) bus <= '{a, 8'h00, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  function logic pl(input bit w);
    return w ? interval_interrupt : watch_interrupt;
  endfunction
  // f: cycles to first pulse, n: cycles between first and second pulse
  task per(input bit w, output int f, output int n);
    f = 0;
    n = 0;
    do begin @(posedge clk); #1 f++; end while (pl(w) !== 1'b1 && f < 5000);
    do begin @(posedge clk); #1 n++; end while (pl(w) !== 1'b1 && n < 5000);
  endtask
  task end_sim;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(WTMR_CTRL_OFS, 8'h00);
    rd(WTMR_STAT_OFS, 8'h00);
    rd(WTMR_MASK_OFS, 8'h00);
    rd(WTMR_CTRL_OFS + 32'h10, 8'h00);
    wr(WTMR_CTRL_OFS, 8'h0c, 8'hff);
    rd(WTMR_CTRL_OFS, 8'h08);
    wr(WTMR_CTRL_OFS, 8'hff, 8'h01);
    rd(WTMR_CTRL_OFS, 8'h09);
    wr(WTMR_CTRL_OFS, 8'h01, 8'hff);
    per(1'b1, f, n);
    chk(n, 16 * DIV);
    wr(WTMR_CTRL_OFS, 8'h00, 8'hff);
    repeat (300) @(posedge clk);
    rd(WTMR_STAT_OFS, 8'h02);
    wr(WTMR_STAT_OFS, 8'h02, 8'hff);
    repeat (300) @(posedge clk);
    rd(WTMR_STAT_OFS, 8'h00);
    wr(WTMR_CTRL_OFS, 8'h01, 8'hff);
    per(1'b1, f, n);
    chk(n, 16 * DIV);
    wr(WTMR_CTRL_OFS, 8'h00, 8'hff);
    #1 chk(irq, 1'b0);
    wr(WTMR_MASK_OFS, 8'h02, 8'hff);
    @(posedge clk) #1 chk(irq, 1'b1);
    wr(WTMR_STAT_OFS, 8'h02, 8'hff);
    @(posedge clk) #1 chk(irq, 1'b0);
    rd(WTMR_STAT_OFS, 8'h00);
    for (int c = 0; c < 6; c++) begin
      wr(WTMR_CTRL_OFS, {1'b0, c[2:0], 4'h1}, 8'hff);
      per(1'b1, f, n);
      chk(n, DIV << (4 + c));
    end
    wr(WTMR_CTRL_OFS, 8'h00, 8'hff);
    wr(WTMR_STAT_OFS, 8'h03, 8'hff);
    wr(WTMR_CTRL_OFS, 8'h0b, 8'hff);
    per(1'b0, f, n);
    chk(f >= 32 * DIV - 4, 1);
    chk(n, 32 * DIV);
    rd(WTMR_STAT_OFS, 8'h03);
    wr(WTMR_CTRL_OFS, 8'h81, 8'hff);
    per(1'b1, f, n);
    chk(n, 32 * SUBH);
    end_sim();
  end
endmodule
